/* wcfc_top.sv */
// cache flush command interpreter with ahb-lite register slave
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
module wcfc_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic media_write_pulse
);
  logic wr_pend_q;
  logic [31:0] addr_q;
  logic [7:0] devhead_q;
  logic [7:0] error_q;
  logic [7:0] status_q;
  logic [5:0] cache_q;
  logic fault_inject_q;
  logic media_busy_q;
  wcfc_pkg::wcfc_state_type state_q;
  wire access = hsel && hready && htrans[1];
  wire cmd_wr = wr_pend_q && addr_q == wcfc_pkg::ADDR_COMMAND;
  wire is_flush = cmd_wr && (hwdata[7:0] == wcfc_pkg::CMD_FLUSH || hwdata[7:0] == wcfc_pkg::CMD_FLUSH_EXT);
  wire idle = state_q == wcfc_pkg::WCFC_IDLE;
  wire media_done;
  wire start_write = state_q == wcfc_pkg::WCFC_FLUSH && !media_busy_q && cache_q != wcfc_pkg::CACHE_RESET;
  wire [31:0] rd_mux =
    (haddr == wcfc_pkg::ADDR_DEVHEAD) ? {24'h0, devhead_q} :
    (haddr == wcfc_pkg::ADDR_ERROR) ? {24'h0, error_q} :
    (haddr == wcfc_pkg::ADDR_STATUS) ? {24'h0, status_q} :
    (haddr == wcfc_pkg::ADDR_CACHE_FILL) ? {26'h0, cache_q} :
    (haddr == wcfc_pkg::ADDR_CONTROL) ? {31'h0, fault_inject_q} : 32'h0;
  wire cache_add = wr_pend_q && addr_q == wcfc_pkg::ADDR_CACHE_FILL && hwdata[0] && idle;

  wcfc_media_writer u_media (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(start_write),
    .done(media_done)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q <= 32'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= access && hwrite;
      if (access) begin
        addr_q <= haddr;
      end
      if (access && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      devhead_q <= wcfc_pkg::DEVHEAD_FIXED_MASK;
      fault_inject_q <= 1'b0;
    end else if (wr_pend_q && addr_q == wcfc_pkg::ADDR_DEVHEAD) begin
      devhead_q <= (hwdata[7:0] & 8'h10) | wcfc_pkg::DEVHEAD_FIXED_MASK;
    end else if (wr_pend_q && addr_q == wcfc_pkg::ADDR_CONTROL) begin
      fault_inject_q <= hwdata[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      media_busy_q <= 1'b0;
      media_write_pulse <= 1'b0;
    end else begin
      media_write_pulse <= start_write;
      if (start_write) begin
        media_busy_q <= 1'b1;
      end else if (media_done) begin
        media_busy_q <= 1'b0;
      end
    end
  end

  // cache fill counter: drained one entry per media write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cache_q <= wcfc_pkg::CACHE_RESET;
    end else if (media_done && !cache_add) begin
      cache_q <= cache_q - 6'h1;
    end else if (cache_add && !media_done && cache_q != 6'h3F) begin
      cache_q <= cache_q + 6'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= wcfc_pkg::WCFC_IDLE;
      status_q <= wcfc_pkg::STATUS_RESET;
      error_q <= wcfc_pkg::ERROR_RESET;
    end else begin
      case (state_q)
        wcfc_pkg::WCFC_IDLE: begin
          if (is_flush && fault_inject_q) begin
            error_q <= 8'h04;
            status_q <= 8'h51;
          end else if (is_flush) begin
            state_q <= wcfc_pkg::WCFC_FLUSH;
            error_q <= wcfc_pkg::ERROR_RESET;
            status_q <= 8'h80;
          end
        end
        wcfc_pkg::WCFC_FLUSH: begin
          if (cache_q == wcfc_pkg::CACHE_RESET && !media_busy_q) begin
            state_q <= wcfc_pkg::WCFC_DONE;
          end
        end
        wcfc_pkg::WCFC_DONE: begin
          state_q <= wcfc_pkg::WCFC_IDLE;
          status_q <= 8'h50;
          error_q <= wcfc_pkg::ERROR_RESET;
        end
        default: begin
          state_q <= wcfc_pkg::WCFC_IDLE;
        end
      endcase
    end
  end

  property p_busy_until_empty;
    @(posedge hclk) disable iff (!hresetn)
      (!status_q[wcfc_pkg::ST_BUSY] && $past(status_q[wcfc_pkg::ST_BUSY])) |-> cache_q == 6'h00 && !media_busy_q;
  endproperty
  a_busy_until_empty: assert property (p_busy_until_empty) else $error("busy cleared with cache not empty");

  property p_flush_starts;
    @(posedge hclk) disable iff (!hresetn)
      (is_flush && !fault_inject_q && idle) |=> status_q == 8'h80;
  endproperty
  a_flush_starts: assert property (p_flush_starts) else $error("flush command not accepted");

  property p_error_bits;
    @(posedge hclk) disable iff (!hresetn)
      (error_q & 8'hFB) == 8'h00;
  endproperty
  a_error_bits: assert property (p_error_bits) else $error("error bit other than abort set");

  property p_abort_pair;
    @(posedge hclk) disable iff (!hresetn)
      error_q[wcfc_pkg::ABORT_BIT] == status_q[wcfc_pkg::ST_ERR];
  endproperty
  a_abort_pair: assert property (p_abort_pair) else $error("abort and error summary differ");

  property p_done_status;
    @(posedge hclk) disable iff (!hresetn)
      state_q == wcfc_pkg::WCFC_DONE |=> status_q == 8'h50 && error_q == 8'h00;
  endproperty
  a_done_status: assert property (p_done_status) else $error("bad completion status");

  property p_drain;
    @(posedge hclk) disable iff (!hresetn)
      media_done && !cache_add |=> cache_q == $past(cache_q) - 6'h1;
  endproperty
  a_drain: assert property (p_drain) else $error("cache entry not retired");

  property p_ext_flush;
    @(posedge hclk) disable iff (!hresetn)
      (cmd_wr && hwdata[7:0] == 8'hEA && idle && !fault_inject_q) |=> state_q == wcfc_pkg::WCFC_FLUSH;
  endproperty
  a_ext_flush: assert property (p_ext_flush) else $error("extended flush not decoded");

  property p_no_fault;
    @(posedge hclk) disable iff (!hresetn)
      !status_q[wcfc_pkg::ST_FAULT] && !status_q[wcfc_pkg::ST_COR] && !status_q[wcfc_pkg::ST_DRQ];
  endproperty
  a_no_fault: assert property (p_no_fault) else $error("fault or corrected bit set");

  property p_write_in_flush;
    @(posedge hclk) disable iff (!hresetn)
      media_write_pulse |-> state_q == wcfc_pkg::WCFC_FLUSH && media_busy_q && status_q[wcfc_pkg::ST_BUSY];
  endproperty
  a_write_in_flush: assert property (p_write_in_flush) else $error("media write outside a flush");

  property p_single_write;
    @(posedge hclk) disable iff (!hresetn)
      media_write_pulse |=> !media_write_pulse && media_busy_q;
  endproperty
  a_single_write: assert property (p_single_write) else $error("media write overlapped");

  property p_hold_while_pending;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == wcfc_pkg::WCFC_FLUSH && (cache_q != 6'h00 || media_busy_q)) |=> state_q == wcfc_pkg::WCFC_FLUSH;
  endproperty
  a_hold_while_pending: assert property (p_hold_while_pending) else $error("flush left with entries pending");

  property p_busy_while_active;
    @(posedge hclk) disable iff (!hresetn)
      state_q != wcfc_pkg::WCFC_IDLE |-> status_q[wcfc_pkg::ST_BUSY] && !status_q[wcfc_pkg::ST_ERR];
  endproperty
  a_busy_while_active: assert property (p_busy_while_active) else $error("busy not shown during flush");

  property p_ready_when_idle;
    @(posedge hclk) disable iff (!hresetn)
      !status_q[wcfc_pkg::ST_BUSY] |-> status_q[wcfc_pkg::ST_READY] && status_q[wcfc_pkg::ST_SEEK];
  endproperty
  a_ready_when_idle: assert property (p_ready_when_idle) else $error("ready or seek clear when not busy");

  property p_abort_now;
    @(posedge hclk) disable iff (!hresetn)
      (is_flush && fault_inject_q && idle) |=>
        state_q == wcfc_pkg::WCFC_IDLE && error_q == 8'h04 && status_q == 8'h51;
  endproperty
  a_abort_now: assert property (p_abort_now) else $error("aborted flush reported wrongly");

  property p_other_code_ignored;
    @(posedge hclk) disable iff (!hresetn)
      (cmd_wr && !is_flush && idle) |=>
        state_q == wcfc_pkg::WCFC_IDLE && $stable(status_q) && $stable(error_q);
  endproperty
  a_other_code_ignored: assert property (p_other_code_ignored) else $error("non-flush code acted on");

  property p_devhead_fixed;
    @(posedge hclk) disable iff (!hresetn)
      devhead_q[7] && devhead_q[5] && (devhead_q & 8'h4F) == 8'h00;
  endproperty
  a_devhead_fixed: assert property (p_devhead_fixed) else $error("device select register malformed");
endmodule

/* wcfc_pkg.sv */
// constants, types and behaviour notes for the write cache flush command block
// Notes on behaviour
// - Command code E7h is decoded as the basic flush, and only the device-select bit and the two fixed-one bits of device/head matter.
// - Command code EAh is decoded as the extended flush, which acts like the basic one and ignores all parameter bytes.
// - On either flush command every pending write-cache entry is written to the media; with fault_inject_q set the code aborts the flush instead and writes none.
// - Successful completion is reported only after all cache contents are committed to the media.
// - At completion busy, device fault and corrected-data are clear, while ready, seek-complete and error summary show the outcome.
package wcfc_pkg;
  localparam logic [7:0] CMD_FLUSH = 8'hE7;
  localparam logic [7:0] CMD_FLUSH_EXT = 8'hEA;
  localparam logic [31:0] ADDR_COMMAND = 32'h0000_0000;
  localparam logic [31:0] ADDR_DEVHEAD = 32'h0000_0004;
  localparam logic [31:0] ADDR_ERROR = 32'h0000_0008;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_000C;
  localparam logic [31:0] ADDR_CACHE_FILL = 32'h0000_0010;
  localparam logic [31:0] ADDR_CONTROL = 32'h0000_0014;
  localparam int ABORT_BIT = 2;
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_FAULT = 5;
  localparam int ST_SEEK = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_COR = 2;
  localparam int ST_ERR = 0;
  localparam int DEV_BIT = 4;
  localparam logic [7:0] DEVHEAD_FIXED_MASK = 8'hA0;
  localparam logic [7:0] STATUS_RESET = 8'h50;
  localparam logic [7:0] ERROR_RESET = 8'h00;
  localparam int CACHE_W = 6;
  localparam logic [5:0] CACHE_RESET = 6'h00;
  localparam int MEDIA_NS = 40;
  localparam int CLK_NS = 5;
  localparam logic [3:0] MEDIA_CYCLES = 4'((MEDIA_NS + CLK_NS - 1) / CLK_NS);
  typedef enum logic [1:0] {
    WCFC_IDLE = 2'b00,
    WCFC_FLUSH = 2'b01,
    WCFC_DONE = 2'b10
  } wcfc_state_type;
endpackage

/* wcfc_media_writer.sv */
// one cache entry write to media, modelled as a fixed busy time
module wcfc_media_writer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  output logic done
);
  logic [3:0] cnt_q;
  logic busy_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q <= wcfc_pkg::MEDIA_CYCLES;
      end else if (busy_q) begin
        if (cnt_q == 4'h1) begin
          busy_q <= 1'b0;
          done <= 1'b1;
        end
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

/* wcfc_host.sv */
// ahb-lite host model issuing task-file register accesses
module wcfc_host (
  input wire logic hclk,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one single word transfer; released lines show the inverse value
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    hwdata <= ~d;
  endtask
endmodule

/* write_cache_flush_cmd_tb.sv */
// self-checking bench for the cache flush command block
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module write_cache_flush_cmd_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel;
  logic hwrite;
  logic hreadyout;
  logic pulse;
  logic hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] q;
  int n_errors = 0;
  int tests_run = 0;
  int pulses = 0;
  int cycles = 0;
  int p0;
  wcfc_host host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  wcfc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .media_write_pulse(pulse));
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (pulse === 1'b1) pulses <= pulses + 1;
  end
  always @(posedge hclk) if (cycles == 5000) begin
    n_errors++;
    final_report();
  end
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    `CHK(q, e)
    `CHK({hresp, hreadyout}, 2'h1)
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic flush(input logic [7:0] code, input int n, input int m);
    int k;
    for (k = 0; k < n; k++) wr(wcfc_pkg::ADDR_CACHE_FILL, 32'h1);
    rd(wcfc_pkg::ADDR_CACHE_FILL, m);
    wr(wcfc_pkg::ADDR_DEVHEAD, 32'h10);
    rd(wcfc_pkg::ADDR_DEVHEAD, 32'hB0);
    p0 = pulses;
    wr(wcfc_pkg::ADDR_COMMAND, {24'h0, code});
    rd(wcfc_pkg::ADDR_STATUS, 32'h80);
    k = 0;
    do begin
      host.xfer(1'b0, wcfc_pkg::ADDR_STATUS, 32'h0, q);
      k++;
    end while (q[7] === 1'b1 && k < 400);
    `CHK(q[7], 1'b0)
    `CHK(pulses - p0, m)
    rd(wcfc_pkg::ADDR_STATUS, 32'h50);
    rd(wcfc_pkg::ADDR_ERROR, 32'h0);
    rd(wcfc_pkg::ADDR_CACHE_FILL, 32'h0);
  endtask
  task automatic final_report();
    if (n_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(wcfc_pkg::ADDR_STATUS, {24'h0, wcfc_pkg::STATUS_RESET});
    rd(wcfc_pkg::ADDR_ERROR, 32'h0);
    rd(wcfc_pkg::ADDR_DEVHEAD, 32'hA0);
    rd(32'h40, 32'h0);
    flush(wcfc_pkg::CMD_FLUSH, 3, 3);
    flush(wcfc_pkg::CMD_FLUSH_EXT, 64, 63);
    // a non-flush code leaves the cache untouched
    wr(wcfc_pkg::ADDR_CACHE_FILL, 32'h1);
    wr(wcfc_pkg::ADDR_COMMAND, 32'h92);
    rd(wcfc_pkg::ADDR_STATUS, 32'h50);
    rd(wcfc_pkg::ADDR_CACHE_FILL, 32'h1);
    wr(wcfc_pkg::ADDR_CONTROL, 32'h1);
    wr(wcfc_pkg::ADDR_COMMAND, 32'hE7);
    rd(wcfc_pkg::ADDR_ERROR, 32'h04);
    rd(wcfc_pkg::ADDR_STATUS, 32'h51);
    rd(wcfc_pkg::ADDR_CACHE_FILL, 32'h1);
    wr(wcfc_pkg::ADDR_CONTROL, 32'h0);
    // a clean flush after an abort clears the abort flag
    flush(wcfc_pkg::CMD_FLUSH_EXT, 0, 1);
    // reset in mid-flush drops busy and the pending entries
    wr(wcfc_pkg::ADDR_CACHE_FILL, 32'h1);
    wr(wcfc_pkg::ADDR_CACHE_FILL, 32'h1);
    wr(wcfc_pkg::ADDR_COMMAND, 32'hE7);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(wcfc_pkg::ADDR_STATUS, {24'h0, wcfc_pkg::STATUS_RESET});
    rd(wcfc_pkg::ADDR_CACHE_FILL, 32'h0);
    flush(wcfc_pkg::CMD_FLUSH, 1, 1);
    final_report();
  end
endmodule
